// [hw/ira_pkg.sv]
// raw interrupt status aggregator: shared constants and types
// assumes a 32-bit apb slave; printed offsets are word indices
package ira_pkg;

    // ========================================================
    // bus and word widths
    localparam int AW = 16;
    localparam int DW = 32;
    localparam int RW = 16;
    localparam int IW = 14;

    typedef logic [RW-1:0] ira_word_t;

    // ========================================================
    // register indices; byte address is four times the index
    localparam logic [IW-1:0] IDX_OVC_TAIL = 14'h0D24;
    localparam logic [IW-1:0] IDX_OVC_B    = 14'h0D25;
    localparam logic [IW-1:0] IDX_UNDER    = 14'h0D26;
    localparam logic [IW-1:0] IDX_PIN      = 14'h0D40;
    localparam logic [IW-1:0] IDX_AON      = 14'h0D55;
    localparam logic [IW-1:0] IDX_CTRL     = 14'h0D60;
    localparam logic [IW-1:0] IDX_MASK1    = 14'h0D61;
    localparam logic [IW-1:0] IDX_MASK2    = 14'h0D62;
    localparam logic [IW-1:0] IDX_SUMMARY  = 14'h0D63;
    localparam logic [IW-1:0] IDX_EVT_STS  = 14'h0D70;
    localparam logic [IW-1:0] IDX_EVT_CLR  = 14'h0D71;
    localparam logic [IW-1:0] IDX_EVT_EN   = 14'h0D72;

    // ========================================================
    // implemented bits of the raw words
    localparam ira_word_t OVC_TAIL_BITS = 16'h37FF;
    localparam ira_word_t OVC_B_BITS    = 16'hFE0B;
    localparam ira_word_t UNDER_BITS    = 16'h077F;

    // ========================================================
    // field positions
    localparam int PIN_FIRST_BIT  = 0;
    localparam int PIN_SECOND_BIT = 1;
    localparam int AON_JACK_BIT   = 0;
    localparam int AON_GP5_BIT    = 2;
    localparam int AON_CLAMP_BIT  = 3;
    localparam int CTRL_SEL_BIT   = 0;
    localparam int SUM_OVC_BIT    = 0;
    localparam int SUM_UND_BIT    = 1;

    // ========================================================
    // event status layout
    localparam int EVW       = 4;
    localparam int EV_OVC    = 0;
    localparam int EV_UND    = 1;
    localparam int EV_JACK   = 2;
    localparam int EV_CLAMP  = 3;

    // ========================================================
    // reset and lane-check constants
    localparam ira_word_t  WORD_ZERO = 16'h0000;
    localparam logic [DW-1:0] BUS_ZERO = 32'h0000_0000;
    localparam logic [1:0]    LANE_OK  = 2'h0;

endpackage : ira_pkg

// [hw/ira_evt_if.sv]
// raw interrupt status aggregator: event bank carrier
// assumes both ends sit on sys_clk
`timescale 1ns/10ps
interface ira_evt_if;
    import ira_pkg::*;
    logic [EVW-1:0] evt;
    logic           clr_wr;
    logic           en_wr;
    logic [EVW-1:0] wdata;
    logic [EVW-1:0] status;
    logic [EVW-1:0] enable;
    logic           irq;
    modport bank (input evt, clr_wr, en_wr, wdata,
                  output status, enable, irq);
    modport host (output evt, clr_wr, en_wr, wdata,
                  input status, enable, irq);
endinterface : ira_evt_if

// [hw/ira_sync.sv]
// raw interrupt status aggregator: three-stage input synchroniser
// assumes inputs arrive from pins or foreign subsystem clocks
`timescale 1ns/10ps
module ira_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    // async level in, filtered level out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // a bit only moves once stages two and three agree
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q      <= (s2_reg & s3_reg) | (q & (s2_reg | s3_reg));
        end
    end
endmodule : ira_sync

// [hw/ira_evt_bank.sv]
// raw interrupt status aggregator: sticky event status bank
// assumes one-cycle event pulses on sys_clk
`timescale 1ns/10ps
module ira_evt_bank
    import ira_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // carrier to the register side
    ira_evt_if.bank   eb
);
    logic [EVW-1:0] clr_mask;
    logic [EVW-1:0] sts_next;
    logic [EVW-1:0] en_next;

    // set beats clear so no event is lost in a clearing cycle
    assign clr_mask = eb.clr_wr ? eb.wdata : '0;
    assign sts_next = (eb.status & ~clr_mask) | eb.evt;
    assign en_next  = eb.en_wr ? eb.wdata : eb.enable;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            eb.status <= '0;
            eb.enable <= '0;
            eb.irq    <= 1'b0;
        end else begin
            eb.status <= sts_next;
            eb.enable <= en_next;
            eb.irq    <= |(sts_next & en_next);
        end
    end
endmodule : ira_evt_bank

// [hw/ira_top.sv]
// raw interrupt status aggregator: apb slave and status logic
// assumes one sys_clk domain at 125 MHz, async active-low reset;
// subsystem error levels and pins are foreign and get synchronised,
// channel interrupt sources come from logic on sys_clk
`timescale 1ns/10ps

// Notes on behaviour
// (RULE1) one overclock raw flag per subsystem
// (RULE2) overclock summary is OR of raw flags
// (RULE3) one underclock raw flag per subsystem
// (RULE4) underclock summary is OR of raw flags
// (RULE5) pin status bit 1: unmasked second sources
// (RULE6) pin status bit 0: unmasked first sources
// (RULE7) bit 3 shows clamp on selected pin
// (RULE8) jack flag high when detect pin low
// (RULE9) raw bits live, read-only, zero after reset
module ira_top
    import ira_pkg::*;
(
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          nrst,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [DW-1:0] pwdata,
    output logic      [DW-1:0] prdata,
    output logic               pready,
    output logic               pslverr,
    // subsystem error levels, foreign clocks
    input  wire logic [RW-1:0] ovc_tail_cond,
    input  wire logic [RW-1:0] ovc_b_cond,
    input  wire logic [RW-1:0] under_cond,
    // interrupt channel sources, sys_clk domain
    input  wire logic [RW-1:0] first_channel_sources,
    input  wire logic [RW-1:0] second_channel_sources,
    // always-on pins and conditions
    input  wire logic          mic_clamp_on_pin_a,
    input  wire logic          mic_clamp_on_pin_b,
    input  wire logic          gpio_five_level,
    input  wire logic          jack_detect_input_n,
    // summary and line status
    output logic               overclock_summary_flag,
    output logic               underclock_summary_flag,
    output logic               first_irq_line_state,
    output logic               second_irq_line_state,
    output logic               accessory_detect_pin_select,
    // interrupt
    output logic               irq
);

    // ========================================================
    // declarations
    logic [RW-1:0]  ovc_tail_s;
    logic [RW-1:0]  ovc_b_s;
    logic [RW-1:0]  under_s;
    logic           clamp_a_s;
    logic           clamp_b_s;
    logic           gp5_s;
    logic           jack_n_s;

    ira_word_t      ovc_tail_reg;
    ira_word_t      ovc_b_reg;
    ira_word_t      under_reg;
    ira_word_t      pin_reg;
    ira_word_t      aon_reg;
    ira_word_t      mask1_reg;
    ira_word_t      mask2_reg;
    ira_word_t      ovc_tail_next;
    ira_word_t      ovc_b_next;
    ira_word_t      under_next;
    ira_word_t      pin_next;
    ira_word_t      aon_next;
    ira_word_t      mask1_next;
    ira_word_t      mask2_next;

    logic           sel_reg;
    logic           sel_next;
    logic           ovc_sum_next;
    logic           und_sum_next;
    logic           first_next;
    logic           second_next;
    logic           clamp_next;
    logic           jack_next;

    logic           ovc_sum_d_reg;
    logic           und_sum_d_reg;
    logic           jack_d_reg;
    logic           clamp_d_reg;
    logic [EVW-1:0] evt_vec;

    logic           setup;
    logic           access;
    logic [IW-1:0]  widx;
    logic           lane_ok;
    logic           hit_ctrl;
    logic           hit_mask1;
    logic           hit_mask2;
    logic           hit_clr;
    logic           hit_en;
    logic           mapped;
    logic [DW-1:0]  rd_word;
    ira_word_t      rd_half;
    ira_word_t      summary_word;
    ira_word_t      ctrl_word;
    ira_word_t      evt_sts_word;
    ira_word_t      evt_en_word;

    ira_evt_if      evb ();

    // ========================================================
    // input synchronisers
    // error levels come from other subsystem clocks
    ira_sync #(.W(RW), .RST_VAL(WORD_ZERO)) u_sync_ovc_tail (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .d       (ovc_tail_cond),
        .q       (ovc_tail_s)
    );

    ira_sync #(.W(RW), .RST_VAL(WORD_ZERO)) u_sync_ovc_b (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .d       (ovc_b_cond),
        .q       (ovc_b_s)
    );

    ira_sync #(.W(RW), .RST_VAL(WORD_ZERO)) u_sync_under (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .d       (under_cond),
        .q       (under_s)
    );

    // jack pin resets high so the flag reads zero after reset
    ira_sync #(.W(4), .RST_VAL(4'h8)) u_sync_aon (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .d       ({jack_detect_input_n, gpio_five_level,
                   mic_clamp_on_pin_b, mic_clamp_on_pin_a}),
        .q       ({jack_n_s, gp5_s, clamp_b_s, clamp_a_s})
    );

    // ========================================================
    // raw status words
    // unimplemented bits are forced low here, not at read time
    assign ovc_tail_next = ovc_tail_s & OVC_TAIL_BITS; // RULE1
    assign ovc_b_next    = ovc_b_s & OVC_B_BITS;       // RULE1
    assign under_next    = under_s & UNDER_BITS;       // RULE3

    // summaries use the raw words so they match what is read
    assign ovc_sum_next = |ovc_tail_reg | |ovc_b_reg; // RULE2
    assign und_sum_next = |under_reg;                 // RULE4

    // a mask bit of one hides its source from the line
    assign first_next  = |(first_channel_sources & ~mask1_reg);  // RULE6
    assign second_next = |(second_channel_sources & ~mask2_reg); // RULE5

    // clamp follows whichever mic detect pin is selected
    assign clamp_next = sel_reg ? clamp_b_s : clamp_a_s; // RULE7
    // detect pin is pulled low when a jack goes in
    assign jack_next  = ~jack_n_s;                       // RULE8

    // pin and always-on words built from the live levels
    always_comb begin
        pin_next = WORD_ZERO;
        pin_next[PIN_FIRST_BIT]  = first_next;  // RULE6
        pin_next[PIN_SECOND_BIT] = second_next; // RULE5
        aon_next = WORD_ZERO;
        aon_next[AON_JACK_BIT]  = jack_next;    // RULE8
        aon_next[AON_GP5_BIT]   = gp5_s;
        aon_next[AON_CLAMP_BIT] = clamp_next;   // RULE7
    end

    // raw words refresh every cycle; no bus path reaches them
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ovc_tail_reg <= WORD_ZERO; // RULE9
            ovc_b_reg    <= WORD_ZERO;
            under_reg    <= WORD_ZERO;
            pin_reg      <= WORD_ZERO;
            aon_reg      <= WORD_ZERO;
        end else begin
            ovc_tail_reg <= ovc_tail_next; // RULE9
            ovc_b_reg    <= ovc_b_next;
            under_reg    <= under_next;
            pin_reg      <= pin_next;
            aon_reg      <= aon_next;
        end
    end

    // summary and line outputs, one flop each
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            overclock_summary_flag  <= 1'b0;
            underclock_summary_flag <= 1'b0;
            first_irq_line_state    <= 1'b0;
            second_irq_line_state   <= 1'b0;
        end else begin
            overclock_summary_flag  <= ovc_sum_next; // RULE2
            underclock_summary_flag <= und_sum_next; // RULE4
            first_irq_line_state    <= first_next;   // RULE6
            second_irq_line_state   <= second_next;  // RULE5
        end
    end

    // ========================================================
    // event detection for the sticky bank
    // rising summaries and clamp, any jack change
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ovc_sum_d_reg <= 1'b0;
            und_sum_d_reg <= 1'b0;
            jack_d_reg    <= 1'b0;
            clamp_d_reg   <= 1'b0;
        end else begin
            ovc_sum_d_reg <= overclock_summary_flag;
            und_sum_d_reg <= underclock_summary_flag;
            jack_d_reg    <= aon_reg[AON_JACK_BIT];
            clamp_d_reg   <= aon_reg[AON_CLAMP_BIT];
        end
    end

    always_comb begin
        evt_vec = '0;
        evt_vec[EV_OVC]   = overclock_summary_flag & ~ovc_sum_d_reg;
        evt_vec[EV_UND]   = underclock_summary_flag & ~und_sum_d_reg;
        evt_vec[EV_JACK]  = aon_reg[AON_JACK_BIT] ^ jack_d_reg;
        evt_vec[EV_CLAMP] = aon_reg[AON_CLAMP_BIT] & ~clamp_d_reg;
    end

    // ========================================================
    // apb decode
    // zero wait state: ready is raised by the setup cycle
    assign setup   = psel & ~penable;
    assign access  = psel & penable & pready;
    assign widx    = paddr[AW-1:2];
    assign lane_ok = (paddr[1:0] == LANE_OK);

    assign hit_ctrl  = lane_ok & (widx == IDX_CTRL);
    assign hit_mask1 = lane_ok & (widx == IDX_MASK1);
    assign hit_mask2 = lane_ok & (widx == IDX_MASK2);
    assign hit_clr   = lane_ok & (widx == IDX_EVT_CLR);
    assign hit_en    = lane_ok & (widx == IDX_EVT_EN);

    // all defined indices, read-only ones included
    assign mapped = lane_ok & (widx == IDX_OVC_TAIL
                             | widx == IDX_OVC_B
                             | widx == IDX_UNDER
                             | widx == IDX_PIN
                             | widx == IDX_AON
                             | widx == IDX_CTRL
                             | widx == IDX_MASK1
                             | widx == IDX_MASK2
                             | widx == IDX_SUMMARY
                             | widx == IDX_EVT_STS
                             | widx == IDX_EVT_CLR
                             | widx == IDX_EVT_EN);

    // ========================================================
    // software-written control
    assign sel_next   = (access & pwrite & hit_ctrl)
                        ? pwdata[CTRL_SEL_BIT] : sel_reg;
    assign mask1_next = (access & pwrite & hit_mask1)
                        ? pwdata[RW-1:0] : mask1_reg;
    assign mask2_next = (access & pwrite & hit_mask2)
                        ? pwdata[RW-1:0] : mask2_reg;

    // masks reset clear so every source reaches its line
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sel_reg   <= 1'b0;
            mask1_reg <= WORD_ZERO;
            mask2_reg <= WORD_ZERO;
        end else begin
            sel_reg   <= sel_next;
            mask1_reg <= mask1_next;
            mask2_reg <= mask2_next;
        end
    end

    // select mirrored on a pin for the analogue clamp switch
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            accessory_detect_pin_select <= 1'b0;
        end else begin
            accessory_detect_pin_select <= sel_next;
        end
    end

    // ========================================================
    // sticky event bank
    assign evb.evt    = evt_vec;
    assign evb.clr_wr = access & pwrite & hit_clr;
    assign evb.en_wr  = access & pwrite & hit_en;
    assign evb.wdata  = pwdata[EVW-1:0];

    ira_evt_bank u_bank (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .eb      (evb.bank)
    );

    assign irq = evb.irq;

    // ========================================================
    // read mux
    always_comb begin
        summary_word = WORD_ZERO;
        summary_word[SUM_OVC_BIT] = overclock_summary_flag;
        summary_word[SUM_UND_BIT] = underclock_summary_flag;
        ctrl_word = WORD_ZERO;
        ctrl_word[CTRL_SEL_BIT] = sel_reg;
        evt_sts_word = WORD_ZERO;
        evt_sts_word[EVW-1:0] = evb.status;
        evt_en_word = WORD_ZERO;
        evt_en_word[EVW-1:0] = evb.enable;
    end

    // clear register is write-only and reads as zero
    always_comb begin
        case (widx)
            IDX_OVC_TAIL: rd_half = ovc_tail_reg;
            IDX_OVC_B:    rd_half = ovc_b_reg;
            IDX_UNDER:    rd_half = under_reg;
            IDX_PIN:      rd_half = pin_reg;
            IDX_AON:      rd_half = aon_reg;
            IDX_CTRL:     rd_half = ctrl_word;
            IDX_MASK1:    rd_half = mask1_reg;
            IDX_MASK2:    rd_half = mask2_reg;
            IDX_SUMMARY:  rd_half = summary_word;
            IDX_EVT_STS:  rd_half = evt_sts_word;
            IDX_EVT_EN:   rd_half = evt_en_word;
            default:      rd_half = WORD_ZERO;
        endcase
    end

    // upper half of the bus always reads zero
    assign rd_word = lane_ok ? {WORD_ZERO, rd_half} : BUS_ZERO;

    // ========================================================
    // apb answer flops
    // read data is caught in setup, so it is one cycle old;
    // refused transfers of either direction leave zero data
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= BUS_ZERO;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            if (setup & (~pwrite | ~mapped)) begin
                prdata <= rd_word;
            end
        end
    end

endmodule : ira_top

// [test/ira_top_properties.sv]
// checker: bus and summary relations seen at the ira_top ports
// assumes it is bound to ira_top, one sys_clk domain
`timescale 1ns/10ps
module ira_top_properties
    import ira_pkg::*;
(
    // clock, reset and bus
    input wire logic          sys_clk,
    input wire logic          nrst,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic [AW-1:0] paddr,
    input wire logic [DW-1:0] prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    // status inputs and outputs
    input wire logic [RW-1:0] ovc_tail_cond,
    input wire logic [RW-1:0] ovc_b_cond,
    input wire logic [RW-1:0] under_cond,
    input wire logic [RW-1:0] first_channel_sources,
    input wire logic [RW-1:0] second_channel_sources,
    input wire logic          overclock_summary_flag,
    input wire logic          underclock_summary_flag,
    input wire logic          first_irq_line_state,
    input wire logic          second_irq_line_state
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ========================================================
    // bus timing: one wait-free access cycle
    pready_setup_a: assert property (
        psel && !penable |=> pready) else $error("no ready");
    pready_pulse_a: assert property (
        pready |=> !pready) else $error("ready too long");
    err_data_a: assert property (
        pslverr |-> pready && prdata == BUS_ZERO) else $error("bad err");
    misalign_a: assert property (
        psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned accepted");
    upper_zero_a: assert property (
        prdata[31:16] == 16'h0000) else $error("upper data set");
    // ========================================================
    // summaries follow the synchronised levels within eight cycles
    ovc_on_a: assert property (
        (|(ovc_b_cond & OVC_B_BITS)) [*8] |=> overclock_summary_flag)
        else $error("ovc summary low");
    ovc_off_a: assert property (
        (ovc_b_cond == WORD_ZERO && ovc_tail_cond == WORD_ZERO) [*8]
        |=> !overclock_summary_flag) else $error("ovc summary high");
    und_on_a: assert property (
        (|(under_cond & UNDER_BITS)) [*8] |=> underclock_summary_flag)
        else $error("und summary low");
    und_off_a: assert property (
        (under_cond == WORD_ZERO) [*8] |=> !underclock_summary_flag)
        else $error("und summary high");
    // a line with no source at all can never be asserted
    first_off_a: assert property (
        (first_channel_sources == WORD_ZERO) [*2]
        |=> !first_irq_line_state) else $error("first line high");
    second_off_a: assert property (
        (second_channel_sources == WORD_ZERO) [*2]
        |=> !second_irq_line_state) else $error("second line high");
    cov_err_c: cover property (pslverr);
    cov_ovc_c: cover property ($rose(overclock_summary_flag));
    cov_line_c: cover property (second_irq_line_state);
endmodule : ira_top_properties

// [test/ira_top_tb.sv]
// testbench: register reads, status levels, masks and the event irq
// assumes ira_top with a wait-free apb slave, inputs driven here
`timescale 1ns/10ps
module ira_top_tb;
    import ira_pkg::*;
    logic          sys_clk, nrst, psel, penable, pwrite;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pwdata, prdata, rd;
    logic          pready, pslverr, err, ovs, uns, l1, l2, sel, irq;
    logic [RW-1:0] ovt, ovb, und, src1, src2;
    logic          cla, clb, gp5, jack_n;
    int            fail_count, checks_done, cyc;
    ira_top i_ira_top (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ovc_tail_cond(ovt), .ovc_b_cond(ovb),
        .under_cond(und), .first_channel_sources(src1),
        .second_channel_sources(src2), .mic_clamp_on_pin_a(cla),
        .mic_clamp_on_pin_b(clb), .gpio_five_level(gp5),
        .jack_detect_input_n(jack_n), .overclock_summary_flag(ovs),
        .underclock_summary_flag(uns), .first_irq_line_state(l1),
        .second_irq_line_state(l2), .accessory_detect_pin_select(sel),
        .irq(irq));
    // ========================================================
    // clock, and a cycle ceiling against hangs
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 8000) begin
            fail_count++;
            stop_test();
        end
    end
    // ========================================================
    // bus and compare helpers
    task automatic xfer(input logic [IW-1:0] ix, input logic w,
                        input logic [DW-1:0] d, input logic [1:0] lo);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= {ix, lo};
        pwrite  <= w;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // values read here are those sampled by this edge
        do @(posedge sys_clk);
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic chk(input logic [DW-1:0] g, e, input string m);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h", $time, m, g);
        end
    endtask : chk
    task automatic rchk(input logic [IW-1:0] ix, input logic [DW-1:0] e,
                        input string m);
        xfer(ix, 1'b0, BUS_ZERO, 2'h0);
        chk(rd, e, m);
        chk({31'h0, err}, 32'h0, "read error");
    endtask : rchk
    task automatic wr(input logic [IW-1:0] ix, input logic [DW-1:0] d);
        xfer(ix, 1'b1, d, 2'h0);
    endtask : wr
    task automatic fchk(input logic f, e, input string m);
        chk({31'h0, f}, {31'h0, e}, m);
    endtask : fchk
    task automatic wt(input int c);
        repeat (c) @(posedge sys_clk);
    endtask : wt
    // ========================================================
    // scenarios
    task automatic t_reset();
        logic [IW-1:0] ix [5] = '{IDX_OVC_TAIL, IDX_OVC_B, IDX_UNDER,
                                  IDX_PIN, IDX_AON};
        foreach (ix[i]) begin
            rchk(ix[i], BUS_ZERO, "reset value");
            wr(ix[i], 32'h0000_FFFF);
            rchk(ix[i], BUS_ZERO, "write ignored");
        end
        fchk(ovs | uns | l1 | l2 | irq, 1'b0, "reset outputs");
    endtask : t_reset
    task automatic t_clock();
        ovt <= OVC_TAIL_BITS;
        wt(10);
        rchk(IDX_OVC_TAIL, {16'h0, OVC_TAIL_BITS}, "ovc tail");
        fchk(ovs, 1'b1, "ovc summary");
        ovt <= WORD_ZERO;
        ovb <= 16'h8000;
        und <= 16'h0001;
        wt(10);
        rchk(IDX_OVC_B, 32'h0000_8000, "ovc b");
        rchk(IDX_OVC_TAIL, BUS_ZERO, "ovc tail clear");
        rchk(IDX_UNDER, 32'h0000_0001, "und low bit");
        rchk(IDX_SUMMARY, 32'h0000_0003, "summaries");
        ovb <= WORD_ZERO;
        und <= 16'h0400;
        wt(10);
        rchk(IDX_UNDER, 32'h0000_0400, "und top bit");
        fchk(ovs, 1'b0, "ovc summary off");
        fchk(uns, 1'b1, "und summary");
        und <= WORD_ZERO;
        wt(10);
        fchk(uns, 1'b0, "und summary off");
    endtask : t_clock
    task automatic t_lines();
        wr(IDX_MASK1, BUS_ZERO);
        wr(IDX_MASK2, BUS_ZERO);
        src1 <= 16'h0010;
        src2 <= 16'h0003;
        wt(3);
        rchk(IDX_PIN, 32'h0000_0003, "pin both");
        fchk(l1, 1'b1, "first line");
        wr(IDX_MASK1, 32'h0000_0010);
        wr(IDX_MASK2, 32'h0000_0001);
        wt(3);
        rchk(IDX_PIN, 32'h0000_0002, "pin masked");
        fchk(l1, 1'b0, "first masked");
        fchk(l2, 1'b1, "second partial");
        wr(IDX_MASK2, 32'h0000_0003);
        wt(3);
        fchk(l2, 1'b0, "second masked");
        src1 <= WORD_ZERO;
        src2 <= WORD_ZERO;
    endtask : t_lines
    task automatic t_aon();
        wr(IDX_EVT_CLR, 32'h0000_000F);
        wr(IDX_EVT_EN, 32'h0000_0004);
        rchk(IDX_EVT_STS, BUS_ZERO, "events clear");
        jack_n <= 1'b0;
        clb    <= 1'b1;
        wt(10);
        rchk(IDX_AON, 32'h0000_0001, "jack in, clamp off pin");
        fchk(irq, 1'b1, "jack irq");
        wr(IDX_EVT_EN, BUS_ZERO);
        wt(2);
        fchk(irq, 1'b0, "irq masked");
        wr(IDX_EVT_EN, 32'h0000_0004);
        wt(2);
        fchk(irq, 1'b1, "irq unmasked");
        wr(IDX_EVT_CLR, 32'h0000_0004);
        wt(2);
        fchk(irq, 1'b0, "irq cleared");
        wr(IDX_CTRL, 32'h0000_0001);
        gp5 <= 1'b1;
        wt(10);
        fchk(sel, 1'b1, "pin select");
        rchk(IDX_AON, 32'h0000_000D, "clamp on pin b");
        jack_n <= 1'b1;
        wt(10);
        rchk(IDX_AON, 32'h0000_000C, "jack out");
        rchk(IDX_EVT_STS, 32'h0000_000C, "clamp and jack events");
    endtask : t_aon
    task automatic t_bad();
        xfer(14'h0100, 1'b0, BUS_ZERO, 2'h0);
        chk({31'h0, err}, 32'h1, "unmapped");
        xfer(IDX_AON, 1'b0, BUS_ZERO, 2'h2);
        chk({31'h0, err}, 32'h1, "misaligned");
        chk(rd, BUS_ZERO, "error data");
    endtask : t_bad
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test
    // ========================================================
    // main sequence; jack pin idles high, meaning no jack
    initial begin
        {nrst, psel, penable, pwrite, cla, clb, gp5} = '0;
        {paddr, pwdata, ovt, ovb, und, src1, src2} = '0;
        jack_n = 1'b1;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_clock();
        t_lines();
        t_aon();
        t_bad();
        stop_test();
    end
endmodule : ira_top_tb
bind ira_top ira_top_properties i_ira_top_properties (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ovc_tail_cond(ovc_tail_cond), .ovc_b_cond(ovc_b_cond),
    .under_cond(under_cond), .first_channel_sources(first_channel_sources),
    .second_channel_sources(second_channel_sources),
    .overclock_summary_flag(overclock_summary_flag),
    .underclock_summary_flag(underclock_summary_flag),
    .first_irq_line_state(first_irq_line_state),
    .second_irq_line_state(second_irq_line_state));
